// ==== include/divider_pkg.sv ====
/*
   Shared constants, types and helper functions for the sequential binary divider.
   Assumes every user writes divider_pkg::name; nothing is imported.
*/
`default_nettype none

package divider_pkg;

   localparam int OPERAND_W = 8;
   localparam int QUOTIENT_W = 16;
   localparam int COUNT_W = 4;
   localparam int CYCLE_W = 5;

   // step counter values
   localparam logic [3:0] COUNT_RESET = 4'h0;
   localparam logic [3:0] COUNT_ALIGNED = 4'h7;
   localparam logic [3:0] COUNT_TERMINAL = 4'hF;

   // bounds on a fixed-point division, in clock periods from the load edge
   localparam int MIN_CYCLES = 11;
   localparam int MAX_CYCLES = 25;

   localparam logic [7:0] OPERAND_ZERO = 8'h00;
   localparam logic [8:0] DIVIDEND_RESET = 9'h000;
   localparam logic [7:0] REMAINDER_RESET = 8'h00;
   localparam logic [15:0] QUOTIENT_RESET = 16'h0000;
   localparam logic [4:0] CYCLE_RESET = 5'h00;
   localparam logic [4:0] CYCLE_FIRST = 5'h01;
   localparam logic [4:0] CYCLE_LIMIT = 5'h1F;

   // gray sequence along idle, prenormalise, align, divide, done
   typedef enum logic [2:0] {
      IDLE = 3'h0,
      PRENORM = 3'h1,
      ALIGN = 3'h3,
      DIVIDE = 3'h2,
      DONE = 3'h6,
      ZERO_DIV = 3'h7
   } state_type;

   typedef struct packed {
      logic [7:0] dividend;
      logic [7:0] divisor;
   } operands_type;

   typedef struct packed {
      logic [15:0] quotient;
      logic [7:0] remainder;
   } result_type;

   typedef struct packed {
      logic busy;
      logic done;
      logic div_zero;
   } status_type;

   // count of leading zeros of a nonzero byte
   function automatic logic [3:0] leading_zeros(input logic [7:0] value);
      logic [3:0] n;
      n = 4'h8;
      for (int i = 0; i < OPERAND_W; i++) begin
         if (value[i]) begin
            n = 4'(OPERAND_W - 1 - i);
         end
      end
      return n;
   endfunction : leading_zeros

   // quotient bit written by a step at a given counter value
   function automatic logic [3:0] bit_index(input logic [3:0] count);
      return COUNT_TERMINAL - count;
   endfunction : bit_index

endpackage : divider_pkg

`default_nettype wire

// ==== rtl/quotient_latch.sv ====
/*
   Sixteen-bit addressable quotient store: cleared as a whole, one bit set at a time.
   Assumes clear and set never need to act on the same edge; clear wins if they do.
*/
`timescale 1ns/100ps
`default_nettype none

module quotient_latch (
   input wire logic clk,               // system clock
   input wire logic reset,             // synchronous reset, active high
   input wire logic clear,             // clears every bit
   input wire logic set_en,            // writes a one at addr
   input wire logic [3:0] addr,        // bit to set
   output logic [15:0] quotient        // stored bits
);

   logic [15:0] bits_r;
   logic [15:0] bits_nxt;

   always_comb begin
      bits_nxt = bits_r;
      if (clear) begin
         bits_nxt = divider_pkg::QUOTIENT_RESET;
      end else if (set_en) begin
         bits_nxt[addr] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bits_r <= divider_pkg::QUOTIENT_RESET;
      end else begin
         bits_r <= bits_nxt;
      end
   end

   assign quotient = bits_r;

endmodule : quotient_latch

`default_nettype wire

// ==== rtl/divider_core.sv ====
/*
   Sequential 8-bit binary divider giving a 16-bit fixed-point quotient and a remainder.
   Assumes a host that pulses load for one clock with operands valid on that edge,
   and float_mode steady across that edge.
*/
`timescale 1ns/100ps
`default_nettype none

module divider_core (
   input wire logic clk,                          // system clock, 200 MHz
   input wire logic reset,                        // synchronous reset, active high
   input wire logic load,                         // start pulse, one clock
   input wire divider_pkg::operands_type operands, // dividend and divisor
   input wire logic float_mode,                   // operands are normalised mantissas
   output divider_pkg::result_type result,        // quotient and remainder
   output divider_pkg::status_type status         // busy, done, divide by zero
);

   divider_pkg::state_type state_r;
   divider_pkg::state_type state_nxt;
   logic [8:0] x_r;
   logic [8:0] x_nxt;
   logic [7:0] y_r;
   logic [7:0] y_nxt;
   logic [3:0] count_r;
   logic [3:0] count_nxt;
   logic sequence_flag_r;
   logic sequence_flag_nxt;
   logic shift_flag_r;
   logic shift_flag_nxt;
   logic done_r;
   logic done_nxt;
   logic div_zero_r;
   logic div_zero_nxt;
   logic float_r;
   logic float_nxt;
   logic [7:0] remainder_r;
   logic [7:0] remainder_nxt;
   logic [4:0] cycle_r;
   logic [4:0] cycle_nxt;

   logic [9:0] trial_sum;
   logic [7:0] difference;
   logic fits;
   logic dividend_load_select;
   logic quotient_set;
   logic [3:0] quotient_addr;
   logic [15:0] quotient;

   // trial subtraction; carry out high means the divisor fits
   always_comb begin
      trial_sum = {1'b0, x_r} + {1'b0, ~{1'b0, y_r}} + 10'h001;
      fits = trial_sum[9];
      difference = trial_sum[7:0];
   end

   assign dividend_load_select = load;
   assign quotient_addr = divider_pkg::bit_index(count_r);
   assign quotient_set = (state_r == divider_pkg::DIVIDE) && fits && !load;

   always_comb begin
      state_nxt = state_r;
      x_nxt = x_r;
      y_nxt = y_r;
      count_nxt = count_r;
      sequence_flag_nxt = sequence_flag_r;
      shift_flag_nxt = shift_flag_r;
      done_nxt = done_r;
      div_zero_nxt = div_zero_r;
      float_nxt = float_r;
      remainder_nxt = remainder_r;
      cycle_nxt = (cycle_r == divider_pkg::CYCLE_LIMIT) ? cycle_r : 5'(cycle_r + 5'h01);
      // load overrides whatever step is in progress
      if (dividend_load_select) begin
         x_nxt = {1'b0, operands.dividend};
         y_nxt = operands.divisor;
         count_nxt = float_mode ? divider_pkg::COUNT_ALIGNED : divider_pkg::COUNT_RESET;
         sequence_flag_nxt = 1'b1;
         shift_flag_nxt = 1'b1;
         done_nxt = 1'b0;
         div_zero_nxt = 1'b0;
         float_nxt = float_mode;
         remainder_nxt = divider_pkg::REMAINDER_RESET;
         cycle_nxt = divider_pkg::CYCLE_FIRST;
         state_nxt = divider_pkg::PRENORM;
         if (float_mode) begin
            sequence_flag_nxt = 1'b0;
            shift_flag_nxt = 1'b0;
            state_nxt = divider_pkg::DIVIDE;
            if (operands.divisor == divider_pkg::OPERAND_ZERO) begin
               div_zero_nxt = 1'b1;
               state_nxt = divider_pkg::ZERO_DIV;
            end
         end
      end else begin
         case (state_r)
            divider_pkg::PRENORM: begin
               if (y_r == divider_pkg::OPERAND_ZERO) begin
                  div_zero_nxt = 1'b1;
                  state_nxt = divider_pkg::ZERO_DIV;
               end else if (x_r[7] || y_r[7]) begin
                  // encoding in the same cycle as the last shift check saves a clock
                  count_nxt = 4'(divider_pkg::COUNT_ALIGNED - divider_pkg::leading_zeros(y_r));
                  sequence_flag_nxt = 1'b0;
                  shift_flag_nxt = 1'b0;
                  state_nxt = y_r[7] ? divider_pkg::DIVIDE : divider_pkg::ALIGN;
               end else begin
                  // shifting both keeps the ratio, so the binary point stays put
                  x_nxt = {x_r[7:0], 1'b0};
                  y_nxt = {y_r[6:0], 1'b0};
               end
            end
            divider_pkg::ALIGN: begin
               y_nxt = {y_r[6:0], 1'b0};
               if (y_r[6]) begin
                  state_nxt = divider_pkg::DIVIDE;
               end
            end
            divider_pkg::DIVIDE: begin
               // x_r[8] set means the dividend certainly exceeds the divisor
               if (fits) begin
                  x_nxt = {difference, 1'b0};
               end else begin
                  x_nxt = {x_r[7:0], 1'b0};
               end
               if (count_r == divider_pkg::COUNT_TERMINAL) begin
                  remainder_nxt = fits ? difference : x_r[7:0];
                  done_nxt = 1'b1;
                  sequence_flag_nxt = 1'b1;
                  state_nxt = divider_pkg::DONE;
               end else begin
                  count_nxt = 4'(count_r + 4'h1);
               end
            end
            divider_pkg::DONE: begin
               state_nxt = divider_pkg::DONE;
            end
            divider_pkg::ZERO_DIV: begin
               state_nxt = divider_pkg::ZERO_DIV;
            end
            default: begin
               state_nxt = divider_pkg::IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= divider_pkg::IDLE;
         x_r <= divider_pkg::DIVIDEND_RESET;
         y_r <= divider_pkg::OPERAND_ZERO;
         count_r <= divider_pkg::COUNT_RESET;
         sequence_flag_r <= 1'b0;
         shift_flag_r <= 1'b0;
         done_r <= 1'b0;
         div_zero_r <= 1'b0;
         float_r <= 1'b0;
         remainder_r <= divider_pkg::REMAINDER_RESET;
         cycle_r <= divider_pkg::CYCLE_RESET;
      end else begin
         state_r <= state_nxt;
         x_r <= x_nxt;
         y_r <= y_nxt;
         count_r <= count_nxt;
         sequence_flag_r <= sequence_flag_nxt;
         shift_flag_r <= shift_flag_nxt;
         done_r <= done_nxt;
         div_zero_r <= div_zero_nxt;
         float_r <= float_nxt;
         remainder_r <= remainder_nxt;
         cycle_r <= cycle_nxt;
      end
   end

   quotient_latch quotient_store (
      .clk(clk),
      .reset(reset),
      .clear(dividend_load_select),
      .set_en(quotient_set),
      .addr(quotient_addr),
      .quotient(quotient)
   );

   assign result.quotient = quotient;
   assign result.remainder = remainder_r;
   assign status.busy = (state_r == divider_pkg::PRENORM) || (state_r == divider_pkg::ALIGN)
      || (state_r == divider_pkg::DIVIDE);
   assign status.done = done_r;
   assign status.div_zero = div_zero_r;

   load_capture_a: assert property (@(posedge clk) disable iff (reset)
      load && !float_mode |=> count_r == divider_pkg::COUNT_RESET && sequence_flag_r
         && shift_flag_r && quotient == divider_pkg::QUOTIENT_RESET
         && x_r == {1'b0, $past(operands.dividend)})
      else $error("load did not initialise the divider");

   divide_time_a: assert property (@(posedge clk) disable iff (reset)
      $rose(done_r) && !float_r |-> cycle_r >= 5'(divider_pkg::MIN_CYCLES)
         && cycle_r <= 5'(divider_pkg::MAX_CYCLES))
      else $error("division time outside 11 to 25 clocks");

   prenorm_stop_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::PRENORM && !(x_r[7] || y_r[7]) && y_r != divider_pkg::OPERAND_ZERO
         && !load |=> state_r == divider_pkg::PRENORM && x_r[8:1] == $past(x_r[7:0]))
      else $error("operands not shifted together");

   // a zero divisor leaves for its own state, so it is kept out of this check
   encode_count_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::PRENORM && (x_r[7] || y_r[7]) && !load
         && y_r != divider_pkg::OPERAND_ZERO
         |=> !sequence_flag_r && count_r + divider_pkg::leading_zeros($past(y_r))
            == divider_pkg::COUNT_ALIGNED)
      else $error("counter not loaded from leading zeros");

   align_hold_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::ALIGN && !load |=> $stable(count_r) && $stable(x_r)
         && y_r == {$past(y_r[6:0]), 1'b0})
      else $error("alignment disturbed counter or dividend");

   aligned_entry_a: assert property (@(posedge clk) disable iff (reset)
      $rose(state_r == divider_pkg::DIVIDE) && !$past(load) |-> y_r[7])
      else $error("divide started with unaligned divisor");

   step_count_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::DIVIDE && count_r != divider_pkg::COUNT_TERMINAL && !load
         |=> count_r == $past(count_r) + 4'h1 && state_r == divider_pkg::DIVIDE)
      else $error("step counter did not advance");

   quotient_bit_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::DIVIDE && !load
         |=> quotient[$past(quotient_addr)] == $past(fits))
      else $error("quotient bit does not match trial subtraction");

   terminal_finish_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::DIVIDE && count_r == divider_pkg::COUNT_TERMINAL && !load
         |=> done_r && sequence_flag_r && !status.busy)
      else $error("terminal count did not complete division");

   zero_never_done_a: assert property (@(posedge clk) disable iff (reset)
      div_zero_r |-> !done_r && state_r == divider_pkg::ZERO_DIV)
      else $error("completion shown for zero divisor");

   float_start_a: assert property (@(posedge clk) disable iff (reset)
      load && float_mode && operands.divisor != divider_pkg::OPERAND_ZERO
         |=> state_r == divider_pkg::DIVIDE && count_r == divider_pkg::COUNT_ALIGNED
         ##9 done_r)
      else $error("floating-point division not nine steps from load");

   result_hold_a: assert property (@(posedge clk) disable iff (reset)
      done_r && !load |=> $stable(result) && done_r)
      else $error("result changed before next load");

   // plain magnitude compare, so a miswired adder input shows up here
   subtract_fit_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::DIVIDE |-> fits == (x_r >= {1'b0, y_r}))
      else $error("trial subtraction carry wrong");

   // only holds once the divisor is aligned, which keeps the dividend below twice it
   top_sum_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::DIVIDE && fits && y_r[7] |-> !trial_sum[8])
      else $error("dropped adder bit was not zero");

   dividend_reload_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::DIVIDE && fits && !load |=> x_r[8:1] == $past(difference))
      else $error("dividend not reloaded from remainder");

   remainder_range_a: assert property (@(posedge clk) disable iff (reset)
      $rose(done_r) |-> result.remainder < y_r)
      else $error("remainder not below aligned divisor");

   zero_detect_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::PRENORM && y_r == divider_pkg::OPERAND_ZERO && !load
         |=> div_zero_r && !status.busy)
      else $error("zero divisor not reported");

   zero_hold_a: assert property (@(posedge clk) disable iff (reset)
      div_zero_r && !load |=> div_zero_r && $stable(result))
      else $error("zero divisor status changed before next load");

   done_idle_a: assert property (@(posedge clk) disable iff (reset)
      done_r |-> !status.busy && state_r == divider_pkg::DONE)
      else $error("busy shown after completion");

   load_busy_a: assert property (@(posedge clk) disable iff (reset)
      load && operands.divisor != divider_pkg::OPERAND_ZERO
         |=> status.busy && !done_r && !div_zero_r)
      else $error("load did not start a division");

   float_flag_a: assert property (@(posedge clk) disable iff (reset)
      load && float_mode |=> !sequence_flag_r && !shift_flag_r)
      else $error("mantissa load left control flags set");

   // alignment with a zero divisor would never leave, and an already aligned one would lose bit 7
   align_bound_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::ALIGN |-> !y_r[7] && y_r != divider_pkg::OPERAND_ZERO)
      else $error("alignment entered with nothing to shift");

   sequence_low_a: assert property (@(posedge clk) disable iff (reset)
      state_r == divider_pkg::ALIGN || state_r == divider_pkg::DIVIDE |-> !sequence_flag_r)
      else $error("sequence flag high while dividing");

endmodule : divider_core

`default_nettype wire

// ==== verif/host_model.sv ====
/*
   Host control logic that stands in front of the divider: turns a bench request
   into a one-clock load pulse with operands valid on the load edge.
   Assumes the bench raises req for exactly one clock per division.
*/
`timescale 1ns/100ps
`default_nettype none

module host_model (
   input wire logic clk,                              // system clock
   input wire logic req,                              // bench asks for a division
   input wire divider_pkg::operands_type req_ops,     // operands to present
   input wire logic req_float,                        // mantissa mode wanted
   output var logic load,                             // load pulse to the divider
   output var divider_pkg::operands_type operands,    // operand lines
   output var logic float_mode                        // mode level
);

   initial begin
      load = 1'b0;
      operands = '0;
      float_mode = 1'b0;
   end

   // pulse is one whole clock, so it covers the falling edge before the load edge
   always @(posedge clk) begin
      load <= req;
      float_mode <= req_float;
      // outside the load edge the lines carry junk, so a late capture shows up
      operands <= req ? req_ops : ~operands;
   end

endmodule : host_model

`default_nettype wire

// ==== verif/sequential_binary_divider_test.sv ====
/*
   Self-checking bench for the divider core: fixed and mantissa divisions,
   zero divisor, restart during a running division.
   Assumes the host model in front of the core and a 200 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHECK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         $display("BAD %s expected %0h seen %0h", what, exp, got); \
         error_cnt++; \
      end \
   end

module sequential_binary_divider_test;

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req = 1'b0;
   divider_pkg::operands_type req_ops = '0;
   logic req_float = 1'b0;
   logic load;
   divider_pkg::operands_type operands;
   logic float_mode;
   divider_pkg::result_type result;
   divider_pkg::status_type status;
   int error_cnt = 0;
   int n_tests = 0;

   // dividend, divisor, mode, quotient, edges to done, divisor after alignment
   logic [7:0] tx [0:6] = '{8'h80, 8'hFF, 8'h01, 8'h03, 8'hC0, 8'hFF, 8'h05};
   logic [7:0] ty [0:6] = '{8'h80, 8'h01, 8'h01, 8'h07, 8'hA0, 8'h80, 8'h03};
   logic tf [0:6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [15:0] tq [0:6] = '{16'h0100, 16'hFF00, 16'h0100, 16'h006D, 16'h0133, 16'h01FE,
                             16'h01AA};
   int tn [0:6] = '{11, 25, 18, 16, 10, 11, 18};
   logic [7:0] ta [0:6] = '{8'h80, 8'h80, 8'h80, 8'hE0, 8'hA0, 8'h80, 8'hC0};

   always #2.5 clk = ~clk;

   host_model HOST (
      .clk(clk),
      .req(req),
      .req_ops(req_ops),
      .req_float(req_float),
      .load(load),
      .operands(operands),
      .float_mode(float_mode)
   );

   divider_core DUT (
      .clk(clk),
      .reset(reset),
      .load(load),
      .operands(operands),
      .float_mode(float_mode),
      .result(result),
      .status(status)
   );

   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   // the load edge is the third edge counted from entry
   task automatic start(input logic [7:0] x, input logic [7:0] y, input logic fm);
      @(posedge clk);
      req <= 1'b1;
      req_ops <= '{dividend: x, divisor: y};
      req_float <= fm;
      @(posedge clk);
      req <= 1'b0;
   endtask : start

   task automatic run_case(input int i);
      int n;
      logic [15:0] q;
      start(tx[i], ty[i], tf[i]);
      for (n = 1; n <= 40; n++) begin
         @(posedge clk);
         #1;
         if (n == 1)
            `CHECK("busy_after_load", 1'b1, status.busy);
         if (status.done === 1'b1)
            break;
      end
      `CHECK("edges_to_done", tn[i], n);
      `CHECK("quotient", tq[i], result.quotient);
      `CHECK("busy_at_done", 1'b0, status.busy);
      `CHECK("remainder_below", 1'b1, result.remainder < ta[i]);
      q = result.quotient;
      repeat (4) @(posedge clk);
      #1;
      `CHECK("quotient_held", q, result.quotient);
      `CHECK("done_held", 1'b1, status.done);
   endtask : run_case

   task automatic zero_case(input logic fm, input int exp_n);
      int n;
      start(8'h5A, 8'h00, fm);
      for (n = 1; n <= 10; n++) begin
         @(posedge clk);
         #1;
         if (status.div_zero === 1'b1)
            break;
      end
      `CHECK("edges_to_div_zero", exp_n, n);
      repeat (30) @(posedge clk);
      #1;
      `CHECK("done_never", 1'b0, status.done);
      `CHECK("div_zero_held", 1'b1, status.div_zero);
   endtask : zero_case

   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      #1;
      `CHECK("result_after_reset", 24'h000000, result);
      `CHECK("status_after_reset", 3'h0, status);
      for (int i = 0; i < 7; i++)
         run_case(i);
      zero_case(1'b0, 2);
      zero_case(1'b1, 1);
      // a new load in mid-division restarts it from scratch
      start(8'hFF, 8'h01, 1'b0);
      repeat (6) @(posedge clk);
      run_case(0);
      test_done();
   end

   // the whole run needs well under a thousand clocks
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      test_done();
   end

endmodule : sequential_binary_divider_test

`default_nettype wire
